// ---- src/led_cfg_pkg.sv ----
/*
 * Constants of the backlight driver configuration bank: register addresses,
 * implemented-bit masks, reset values, field positions and decode tables.
 * Assumes a byte-wide register port driven by an external serial engine.
 */
package led_cfg_pkg;

    localparam int NUM_CH = 6;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register addresses.
    localparam logic [7:0] ADDR_CHANNEL_DISABLE_CTRL = 8'h01;
    localparam logic [7:0] ADDR_FREQ_PHASE_CFG = 8'h02;
    localparam logic [7:0] ADDR_GAIN_TIMER_CFG = 8'h03;
    localparam logic [7:0] ADDR_PROTECT_THRESHOLD_CFG = 8'h04;
    localparam logic [7:0] ADDR_RAMP_ROLE_CFG = 8'h05;
    localparam logic [7:0] ADDR_FAULT_MASK_MAIN = 8'h06;
    localparam logic [7:0] ADDR_SHORT_FAULT_MASK = 8'h07;

    // Implemented bits; the others are dropped on write and read as zero.
    localparam logic [7:0] MASK_CHANNEL_DISABLE = 8'h3f;
    localparam logic [7:0] MASK_FREQ_PHASE = 8'hff;
    localparam logic [7:0] MASK_GAIN_TIMER = 8'hff;
    localparam logic [7:0] MASK_PROTECT_THRESHOLD = 8'hff;
    localparam logic [7:0] MASK_RAMP_ROLE = 8'h3f;
    localparam logic [7:0] MASK_FAULT_MAIN = 8'hff;
    localparam logic [7:0] MASK_SHORT_FAULT = 8'h3f;
    localparam logic [7:0] RESET_VALUE = 8'h00;

    // Field positions.
    localparam int PHASE_LSB = 0;
    localparam int FREQ_LSB = 3;
    localparam int DIM_LSB = 0;
    localparam int SS_LSB = 4;
    localparam int FT_LSB = 6;
    localparam int SHORT_THR_LSB = 0;
    localparam int OVP_THR_LSB = 4;
    localparam int OFF_LSB = 0;
    localparam int ON_LSB = 2;
    localparam int ROLE_SEL_BIT = 4;
    localparam int ROLE_SOFT_BIT = 5;
    localparam int OVP_MASK_BIT = 6;
    localparam int SC_MASK_BIT = 7;

    // Frequency multiplier in eighths; code zero equals unity.
    localparam logic [5:0] FREQ_UNITY_EIGHTHS = 6'h08;

    // Timer scale codes give quarters of the base duration.
    localparam logic [3:0] SCALE_QUARTERS [4] = '{4'h4, 4'h8, 4'h2, 4'h1};

    // Analog dimming gain in thousandths.
    localparam logic [7:0] DIM_GAIN_MILLI [16] = '{
        8'd200, 8'd194, 8'd188, 8'd181, 8'd175, 8'd169, 8'd163, 8'd156,
        8'd150, 8'd144, 8'd138, 8'd131, 8'd125, 8'd119, 8'd113, 8'd106};

    // Thresholds in units of 10 mV.
    localparam logic [8:0] OVP_MAX_CV = 9'd300;
    localparam logic [8:0] OVP_MIN_CV = 9'd90;
    localparam logic [8:0] OVP_STEP_CV = 9'd15;
    localparam logic [8:0] SHORT_LOW_CV = 9'd80;
    localparam logic [8:0] SHORT_BASE_CV = 9'd100;
    localparam logic [8:0] SHORT_STEP_CV = 9'd20;
    localparam logic [3:0] SHORT_BASE_CODE = 4'h5;

    // Ramp lengths in switching clocks, carried as half clocks.
    localparam int SOFT_ON_BASE_CLK = 10;
    localparam int SOFT_OFF_BASE_CLK = 15;
    localparam logic [6:0] ON_HALF_BASE = 7'(2 * SOFT_ON_BASE_CLK);
    localparam logic [6:0] OFF_HALF_BASE = 7'(2 * SOFT_OFF_BASE_CLK);

    localparam logic [1:0] ON_OFF = 2'h0;
    localparam logic [1:0] ON_DOUBLE = 2'h1;
    localparam logic [1:0] ON_BASE = 2'h2;
    localparam logic [1:0] ON_HALF = 2'h3;
    localparam logic [1:0] OFF_BASE = 2'h0;
    localparam logic [1:0] OFF_DOUBLE = 2'h1;
    localparam logic [1:0] OFF_HALF = 2'h2;

    localparam logic [2:0] PHASE_MAX_CODE = 3'h5;

endpackage

// ---- src/chan_link_if.sv ----
/*
 * Carries the per-channel controls between the register bank and the
 * channel gating logic. Assumes one bank and one gating instance.
 */
`timescale 1ns/1ps
`default_nettype none

interface chan_link_if;
    logic pwm_level;
    logic [5:0] dis_req;
    logic [5:0] open_mask;
    logic [5:0] short_mask;
    logic [5:0] dis_eff;
    logic [5:0] drive;
    logic [5:0] open_en;
    logic [5:0] short_en;

    modport bank (output pwm_level, dis_req, open_mask, short_mask,
                  input dis_eff, drive, open_en, short_en);
    modport gate (input pwm_level, dis_req, open_mask, short_mask,
                  output dis_eff, drive, open_en, short_en);
endinterface

`default_nettype wire

// ---- src/pin_sync.sv ----
/*
 * Three-stage synchroniser with agreement filter for pin inputs.
 * Assumes the inputs are asynchronous to mclk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } sync_t;

    sync_t st_r;
    sync_t st_nxt;

    // A bit changes once the second and third stage agree on it.
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.lvl[i] = st_r.s3[i];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_o = st_r.lvl;

endmodule // pin_sync

`default_nettype wire

// ---- src/chan_gate.sv ----
/*
 * Per-channel drive and fault-detect enables. Assumes the PWM level
 * arrives already synchronised to mclk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module chan_gate (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    chan_link_if.gate link
);

    typedef struct packed {
        logic [5:0] dis_eff;
        logic [5:0] drive;
        logic [5:0] open_en;
        logic [5:0] short_en;
    } gate_t;

    gate_t st_r;
    gate_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (!link.pwm_level) begin
            st_nxt.dis_eff = link.dis_req;
        end
        st_nxt.drive = {6{link.pwm_level}} & ~st_nxt.dis_eff;
        st_nxt.open_en = ~st_nxt.dis_eff & ~link.open_mask;
        st_nxt.short_en = ~st_nxt.dis_eff & ~link.short_mask;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.dis_eff = st_r.dis_eff;
    assign link.drive = st_r.drive;
    assign link.open_en = st_r.open_en;
    assign link.short_en = st_r.short_en;

endmodule // chan_gate

`default_nettype wire

// ---- src/led_driver_config_regs.sv ----
/*
 * Configuration register bank of a six-channel backlight LED driver, with
 * the decode of every field into the values the analog side consumes.
 * Assumes a serial bus engine presents single-cycle read and write strobes
 * with a byte address, and that the PWM and current-sense pins are async.
 */
// How it works
// - Clear disable bit lets channel follow PWM.
// - Disabled channels never detect open or short.
// - Frequency code scales base in eighths.
// - Phase code selects one to six phases.
// - Fault timer scale: 1x, 2x, half, quarter.
// - Soft-start scale uses the same encoding.
// - Dimming gain from 0.200 down to 0.106.
// - Overvoltage level 0.90 V to 3.00 V.
// - Short level 0.8 V, then 1.0-3.0 V.
// - Short code zero selects the external pin.
// - Role source: current-sense pin or register.
// - Soft role bit honored only when selected.
// - Soft-on ramp: off, 2x, 10 clocks, half.
// - Soft-off ramp: 15 clocks, 2x, half.
// - Soft-on setting clamps the soft-off length.
// - Mask bits block short-circuit and overvoltage detection.
// - Open-mask bits block per-channel open detection.
// - Short-mask bits block per-channel short detection.
// - Unimplemented bits ignore writes, read zero.
// - Disable waits for PWM low; phase waits rise.
`timescale 1ns/1ps
`default_nettype none

module led_driver_config_regs (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [led_cfg_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [led_cfg_pkg::DATA_W-1:0] reg_wdata_i,
    output logic [led_cfg_pkg::DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic pwm_i,
    input wire logic current_sense_detect_i,
    output logic [5:0] led_drive_o,
    output logic [5:0] open_detect_en_o,
    output logic [5:0] short_detect_en_o,
    output logic short_circuit_detect_en_o,
    output logic overvoltage_detect_en_o,
    output logic [5:0] switch_freq_multiplier_o,
    output logic [2:0] phase_count_o,
    output logic [3:0] fault_timer_scale_o,
    output logic [3:0] softstart_scale_o,
    output logic [7:0] dim_gain_o,
    output logic [8:0] overvoltage_threshold_o,
    output logic [8:0] short_threshold_o,
    output logic short_ref_external_o,
    output logic role_slave_o,
    output logic soft_on_en_o,
    output logic [6:0] ramp_on_half_o,
    output logic [6:0] ramp_off_half_o
);

    import led_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [7:0] channel_disable_ctrl;
        logic [7:0] freq_phase_cfg;
        logic [7:0] gain_timer_cfg;
        logic [7:0] protect_threshold_cfg;
        logic [7:0] ramp_role_cfg;
        logic [7:0] fault_mask_main;
        logic [7:0] short_fault_mask;
        logic pwm_d;
        logic [2:0] phase_act;
        logic [7:0] rdata;
        logic rvalid;
        logic [5:0] freq_mult;
        logic [3:0] ft_scale;
        logic [3:0] ss_scale;
        logic [7:0] dim;
        logic [8:0] ovp_cv;
        logic [8:0] short_cv;
        logic short_ext;
        logic slave;
        logic soft_on_en;
        logic [6:0] on_half;
        logic [6:0] off_half;
        logic sc_en;
        logic ov_en;
    } bank_t;

    bank_t st_r;
    bank_t st_nxt;

    logic pwm_level;
    logic cs_level;

    chan_link_if link ();

    ////////////////////////////////////////////////////////////////////////////

    pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i({current_sense_detect_i, pwm_i}),
        .level_o({cs_level, pwm_level})
    );

    chan_gate u_chan_gate (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .link(link.gate)
    );

    assign link.pwm_level = pwm_level;
    assign link.dis_req = st_r.channel_disable_ctrl[5:0];
    assign link.open_mask = st_r.fault_mask_main[5:0];
    assign link.short_mask = st_r.short_fault_mask[5:0];

    ////////////////////////////////////////////////////////////////////////////

    logic [2:0] phase_code;
    logic [4:0] freq_code;
    logic [3:0] ovp_code;
    logic [3:0] short_code;
    logic [1:0] on_code;
    logic [1:0] off_code;

    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        st_nxt.pwm_d = pwm_level;

        // Stores keep only implemented bits.
        if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_CHANNEL_DISABLE_CTRL: begin
                    st_nxt.channel_disable_ctrl = reg_wdata_i & MASK_CHANNEL_DISABLE;
                end
                ADDR_FREQ_PHASE_CFG: begin
                    st_nxt.freq_phase_cfg = reg_wdata_i & MASK_FREQ_PHASE;
                end
                ADDR_GAIN_TIMER_CFG: begin
                    st_nxt.gain_timer_cfg = reg_wdata_i & MASK_GAIN_TIMER;
                end
                ADDR_PROTECT_THRESHOLD_CFG: begin
                    st_nxt.protect_threshold_cfg = reg_wdata_i & MASK_PROTECT_THRESHOLD;
                end
                ADDR_RAMP_ROLE_CFG: begin
                    st_nxt.ramp_role_cfg = reg_wdata_i & MASK_RAMP_ROLE;
                end
                ADDR_FAULT_MASK_MAIN: begin
                    st_nxt.fault_mask_main = reg_wdata_i & MASK_FAULT_MAIN;
                end
                ADDR_SHORT_FAULT_MASK: begin
                    st_nxt.short_fault_mask = reg_wdata_i & MASK_SHORT_FAULT;
                end
                default: begin
                end
            endcase
        end

        // Reads return the stored value; unmapped addresses read zero.
        if (reg_rd_i) begin
            st_nxt.rvalid = 1'b1;
            case (reg_addr_i)
                ADDR_CHANNEL_DISABLE_CTRL: st_nxt.rdata = st_r.channel_disable_ctrl;
                ADDR_FREQ_PHASE_CFG: st_nxt.rdata = st_r.freq_phase_cfg;
                ADDR_GAIN_TIMER_CFG: st_nxt.rdata = st_r.gain_timer_cfg;
                ADDR_PROTECT_THRESHOLD_CFG: st_nxt.rdata = st_r.protect_threshold_cfg;
                ADDR_RAMP_ROLE_CFG: st_nxt.rdata = st_r.ramp_role_cfg;
                ADDR_FAULT_MASK_MAIN: st_nxt.rdata = st_r.fault_mask_main;
                ADDR_SHORT_FAULT_MASK: st_nxt.rdata = st_r.short_fault_mask;
                default: st_nxt.rdata = RESET_VALUE;
            endcase
        end

        // Phase count moves to the active copy at a PWM rising edge only.
        phase_code = st_r.freq_phase_cfg[PHASE_LSB +: 3];
        if (pwm_level && !st_r.pwm_d) begin
            if (phase_code > PHASE_MAX_CODE) begin
                st_nxt.phase_act = 3'h0;
            end else begin
                st_nxt.phase_act = phase_code;
            end
        end

        // Code zero and code seven both give unity.
        freq_code = st_r.freq_phase_cfg[FREQ_LSB +: 5];
        if (freq_code == 5'h00) begin
            st_nxt.freq_mult = FREQ_UNITY_EIGHTHS;
        end else begin
            st_nxt.freq_mult = 6'(freq_code) + 6'h01;
        end

        st_nxt.ft_scale = SCALE_QUARTERS[st_r.gain_timer_cfg[FT_LSB +: 2]];
        st_nxt.ss_scale = SCALE_QUARTERS[st_r.gain_timer_cfg[SS_LSB +: 2]];
        st_nxt.dim = DIM_GAIN_MILLI[st_r.gain_timer_cfg[DIM_LSB +: 4]];

        ovp_code = st_r.protect_threshold_cfg[OVP_THR_LSB +: 4];
        if (ovp_code == 4'h0 || ovp_code == 4'hf) begin
            st_nxt.ovp_cv = OVP_MAX_CV;
        end else begin
            st_nxt.ovp_cv = OVP_MIN_CV + OVP_STEP_CV * (9'(ovp_code) - 9'd1);
        end

        short_code = st_r.protect_threshold_cfg[SHORT_THR_LSB +: 4];
        st_nxt.short_ext = (short_code == 4'h0);
        if (short_code == 4'h0) begin
            st_nxt.short_cv = 9'd0;
        end else if (short_code < SHORT_BASE_CODE) begin
            st_nxt.short_cv = SHORT_LOW_CV;
        end else begin
            st_nxt.short_cv = SHORT_BASE_CV
                + SHORT_STEP_CV * (9'(short_code) - 9'(SHORT_BASE_CODE));
        end

        if (st_r.ramp_role_cfg[ROLE_SEL_BIT]) begin
            st_nxt.slave = st_r.ramp_role_cfg[ROLE_SOFT_BIT];
        end else begin
            st_nxt.slave = cs_level;
        end

        on_code = st_r.ramp_role_cfg[ON_LSB +: 2];
        off_code = st_r.ramp_role_cfg[OFF_LSB +: 2];
        st_nxt.soft_on_en = (on_code != ON_OFF);
        case (on_code)
            ON_DOUBLE: st_nxt.on_half = 7'(2 * ON_HALF_BASE);
            ON_BASE: st_nxt.on_half = ON_HALF_BASE;
            ON_HALF: st_nxt.on_half = ON_HALF_BASE >> 1;
            default: st_nxt.on_half = 7'h00;
        endcase
        case (off_code)
            OFF_DOUBLE: st_nxt.off_half = 7'(2 * OFF_HALF_BASE);
            OFF_HALF: st_nxt.off_half = OFF_HALF_BASE >> 1;
            default: st_nxt.off_half = OFF_HALF_BASE;
        endcase
        if (on_code == ON_BASE && off_code == OFF_DOUBLE) begin
            st_nxt.off_half = OFF_HALF_BASE;
        end
        if (on_code == ON_HALF && (off_code == OFF_BASE || off_code == OFF_DOUBLE)) begin
            st_nxt.off_half = OFF_HALF_BASE >> 1;
        end

        st_nxt.sc_en = ~st_r.fault_mask_main[SC_MASK_BIT];
        st_nxt.ov_en = ~st_r.fault_mask_main[OVP_MASK_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o = st_r.rdata;
    assign reg_rvalid_o = st_r.rvalid;
    assign led_drive_o = link.drive;
    assign open_detect_en_o = link.open_en;
    assign short_detect_en_o = link.short_en;
    assign short_circuit_detect_en_o = st_r.sc_en;
    assign overvoltage_detect_en_o = st_r.ov_en;
    assign switch_freq_multiplier_o = st_r.freq_mult;
    assign phase_count_o = st_r.phase_act;
    assign fault_timer_scale_o = st_r.ft_scale;
    assign softstart_scale_o = st_r.ss_scale;
    assign dim_gain_o = st_r.dim;
    assign overvoltage_threshold_o = st_r.ovp_cv;
    assign short_threshold_o = st_r.short_cv;
    assign short_ref_external_o = st_r.short_ext;
    assign role_slave_o = st_r.slave;
    assign soft_on_en_o = st_r.soft_on_en;
    assign ramp_on_half_o = st_r.on_half;
    assign ramp_off_half_o = st_r.off_half;

endmodule // led_driver_config_regs

`default_nettype wire

// ---- verif/led_cfg_properties.sv ----
/*
 * Port assertions for the LED driver configuration bank.
 * Assumes it is bound to led_driver_config_regs and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module led_cfg_props (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic pwm_i,
    input wire logic [5:0] led_drive_o,
    input wire logic [5:0] open_detect_en_o,
    input wire logic [5:0] short_detect_en_o,
    input wire logic short_circuit_detect_en_o,
    input wire logic overvoltage_detect_en_o,
    input wire logic [5:0] switch_freq_multiplier_o,
    input wire logic [2:0] phase_count_o,
    input wire logic [7:0] dim_gain_o,
    input wire logic [8:0] overvoltage_threshold_o,
    input wire logic role_slave_o,
    input wire logic soft_on_en_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    ////////////////////////////////////////////////////////////////////////
    unused_bits_a: assert property (reg_rd_i && reg_addr_i inside {8'h01, 8'h05, 8'h07}
        |=> reg_rdata_o[7:6] == 2'h0) else $error("unimplemented bits read nonzero");
    unmapped_read_a: assert property (reg_rd_i && (reg_addr_i == 8'h00 || reg_addr_i > 8'h07)
        |=> reg_rdata_o == 8'h00) else $error("unmapped read nonzero");
    sc_mask_a: assert property (reg_wr_i && reg_addr_i == 8'h06
        |-> ##2 short_circuit_detect_en_o == !$past(reg_wdata_i[7], 2)) else $error("sc enable");
    ov_mask_a: assert property (reg_wr_i && reg_addr_i == 8'h06
        |-> ##2 overvoltage_detect_en_o == !$past(reg_wdata_i[6], 2)) else $error("ov enable");
    open_mask_a: assert property (reg_wr_i && reg_addr_i == 8'h06
        |-> ##2 (open_detect_en_o & $past(reg_wdata_i[5:0], 2)) == 6'h00) else $error("open mask");
    short_mask_a: assert property (reg_wr_i && reg_addr_i == 8'h07
        |-> ##2 (short_detect_en_o & $past(reg_wdata_i[5:0], 2)) == 6'h00) else $error("short mask");
    disabled_quiet_a: assert property ((!pwm_i)[*8] ##0 (reg_wr_i && reg_addr_i == 8'h01)
        |-> ##2 ((led_drive_o | open_detect_en_o | short_detect_en_o)
        & $past(reg_wdata_i[5:0], 2)) == 6'h00) else $error("disabled channel active");
    freq_code_a: assert property (reg_wr_i && reg_addr_i == 8'h02 |-> ##2
        switch_freq_multiplier_o == (($past(reg_wdata_i[7:3], 2) == 5'h00) ? 6'h08
        : 6'($past(reg_wdata_i[7:3], 2)) + 6'h01)) else $error("freq multiplier");
    ovp_level_a: assert property (reg_wr_i && reg_addr_i == 8'h04 |-> ##2
        overvoltage_threshold_o == (($past(reg_wdata_i[7:4], 2) == 4'h0) ? 9'h12c
        : 9'h04b + 9'h00f * 9'($past(reg_wdata_i[7:4], 2)))) else $error("ovp level");
    soft_role_a: assert property (reg_wr_i && reg_addr_i == 8'h05 && reg_wdata_i[4]
        |-> ##2 role_slave_o == $past(reg_wdata_i[5], 2)) else $error("soft role");
    soft_on_a: assert property (reg_wr_i && reg_addr_i == 8'h05
        |-> ##2 soft_on_en_o == ($past(reg_wdata_i[3:2], 2) != 2'h0)) else $error("soft on");
    pwm_low_a: assert property ((!pwm_i)[*8] |-> led_drive_o == 6'h00)
        else $error("drive without pwm");
    phase_hold_a: assert property ((!pwm_i)[*8] |-> $stable(phase_count_o))
        else $error("phase moved without pwm rise");
    reset_codes_a: assert property ($fell(sys_rst_i) |-> ##2 dim_gain_o == 8'hc8
        && overvoltage_threshold_o == 9'h12c && switch_freq_multiplier_o == 6'h08)
        else $error("reset codes");

    cover property (reg_wr_i && reg_addr_i == 8'h01 && pwm_i);
    cover property (reg_rd_i && reg_addr_i > 8'h07);
    cover property (pwm_i && phase_count_o == 3'h5);
endmodule // led_cfg_props

bind led_driver_config_regs led_cfg_props i_props (.*);

`default_nettype wire

// ---- verif/cfg_host.sv ----
/*
 * Host model issuing single-byte register strobes to the bank.
 * Assumes the bench calls its tasks; it drives at the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module cfg_host (
    input wire logic mclk_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);
    int unsigned gap = 0;

    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        repeat (gap) @(negedge mclk_i);
        @(negedge mclk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge mclk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        repeat (gap) @(negedge mclk_i);
        @(negedge mclk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge mclk_i);
        rd_o = 1'b0;
        d = rdata_i;
        v = rvalid_i;
    endtask
endmodule // cfg_host

`default_nettype wire

// ---- verif/led_driver_config_regs_bench.sv ----
/*
 * Self-checking bench for the LED driver configuration bank.
 * Assumes the host model and the bound property checker are compiled.
 */
`timescale 1ns/1ps
`default_nettype none

module led_driver_config_regs_bench;
    import led_cfg_pkg::*;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic pwm_i = 1'b0;
    logic current_sense_detect_i = 1'b0;
    logic reg_wr_i, reg_rd_i, reg_rvalid_o, short_circuit_detect_en_o;
    logic overvoltage_detect_en_o, short_ref_external_o, role_slave_o, soft_on_en_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, dim_gain_o;
    logic [5:0] led_drive_o, open_detect_en_o, short_detect_en_o, switch_freq_multiplier_o;
    logic [2:0] phase_count_o;
    logic [3:0] fault_timer_scale_o, softstart_scale_o;
    logic [8:0] overvoltage_threshold_o, short_threshold_o;
    logic [6:0] ramp_on_half_o, ramp_off_half_o;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] m [8] = '{default: 8'h00};
    logic [7:0] msk [8] = '{8'h00, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h3f};
    logic [7:0] dim_tab [16] = '{8'hc8, 8'hc2, 8'hbc, 8'hb5, 8'haf, 8'ha9, 8'ha3, 8'h9c,
        8'h96, 8'h90, 8'h8a, 8'h83, 8'h7d, 8'h77, 8'h71, 8'h6a};

    always #2.5 mclk_i = ~mclk_i;

    led_driver_config_regs i_dut (.mclk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
        .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .pwm_i, .current_sense_detect_i,
        .led_drive_o, .open_detect_en_o, .short_detect_en_o, .short_circuit_detect_en_o,
        .overvoltage_detect_en_o, .switch_freq_multiplier_o, .phase_count_o,
        .fault_timer_scale_o, .softstart_scale_o, .dim_gain_o, .overvoltage_threshold_o,
        .short_threshold_o, .short_ref_external_o, .role_slave_o, .soft_on_en_o,
        .ramp_on_half_o, .ramp_off_half_o);

    cfg_host i_host (.mclk_i, .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o),
        .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] scale_exp(input logic [1:0] c);
        return c == 2'h0 ? 4'h4 : c == 2'h1 ? 4'h8 : c == 2'h2 ? 4'h2 : 4'h1;
    endfunction

    function automatic logic [6:0] on_exp(input logic [1:0] c);
        return c == 2'h0 ? 7'h00 : c == 2'h1 ? 7'h28 : c == 2'h2 ? 7'h14 : 7'h0a;
    endfunction

    function automatic logic [6:0] off_exp(input logic [1:0] on, input logic [1:0] c);
        if (on == 2'h3 && c != 2'h3) begin
            return 7'h0f;
        end
        if (c == 2'h1) begin
            return on == 2'h2 ? 7'h1e : 7'h3c;
        end
        return c == 2'h2 ? 7'h0f : 7'h1e;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic check_all();
        logic [7:0] r;
        logic [3:0] s;
        r = m[5];
        s = m[4][3:0];
        check(switch_freq_multiplier_o, m[2][7:3] == 5'h00 ? 6'h08 : 6'(m[2][7:3]) + 6'h01,
            "freq");
        check(fault_timer_scale_o, scale_exp(m[3][7:6]), "timer");
        check(softstart_scale_o, scale_exp(m[3][5:4]), "softstart");
        check(dim_gain_o, dim_tab[m[3][3:0]], "gain");
        check(overvoltage_threshold_o, m[4][7:4] == 4'h0 ? 9'h12c
            : 9'h04b + 9'h00f * 9'(m[4][7:4]), "ovp");
        check(short_threshold_o, s == 4'h0 ? 9'h000 : s < 4'h5 ? 9'h050
            : 9'h064 + 9'h014 * 9'(s - 4'h5), "short level");
        check(short_ref_external_o, s == 4'h0, "short ref");
        check(role_slave_o, r[4] ? r[5] : current_sense_detect_i, "role");
        check(soft_on_en_o, r[3:2] != 2'h0, "soft on");
        check(ramp_on_half_o, on_exp(r[3:2]), "ramp on");
        check(ramp_off_half_o, off_exp(r[3:2], r[1:0]), "ramp off");
        check(short_circuit_detect_en_o, !m[6][7], "sc");
        check(overvoltage_detect_en_o, !m[6][6], "ov");
        check(open_detect_en_o, 6'(~m[1] & ~m[6]), "open");
        check(short_detect_en_o, 6'(~m[1] & ~m[7]), "short en");
    endtask

    task automatic end_of_test();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int a, n, seed_ret;
        logic [7:0] d, wd, dv;
        logic v;
        logic [2:0] ph;
        seed_ret = $urandom(84475);
        ph = 3'h0;
        repeat (3) @(negedge mclk_i);
        sys_rst_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        for (a = 0; a < 9; a++) begin
            i_host.read_reg(8'(a), d, v);
            check(v, 1'b1, "rvalid");
            check(d, 8'h00, "reset read");
        end
        check_all();
        i_host.write_reg(8'h08, 8'hff);
        i_host.read_reg(8'h08, d, v);
        check(d, 8'h00, "unmapped");
        for (n = 0; n < 60; n++) begin
            a = n < 14 ? 1 + n / 2 : 1 + int'($urandom % 7);
            wd = n < 14 ? (n % 2 == 1 ? 8'hff : 8'h00) : 8'($urandom);
            current_sense_detect_i = 1'($urandom);
            i_host.gap = $urandom % 3;
            i_host.write_reg(8'(a), wd);
            m[a] = wd & msk[a];
            repeat (6) @(negedge mclk_i);
            check_all();
            i_host.read_reg(8'(a), d, v);
            check(d, m[a], "readback");
        end
        for (n = 0; n < 8; n++) begin
            dv = 8'($urandom) & 8'h3f;
            i_host.write_reg(8'h01, dv);
            i_host.write_reg(8'h02, {5'h00, 3'(n)});
            m[1] = dv;
            m[2] = {5'h00, 3'(n)};
            repeat (6) @(negedge mclk_i);
            check(phase_count_o, ph, "phase held");
            check(led_drive_o, 6'h00, "drive off");
            pwm_i = 1'b1;
            repeat (8) @(negedge mclk_i);
            ph = n < 6 ? 3'(n) : 3'h0;
            check(phase_count_o, ph, "phase");
            check(led_drive_o, 6'(~dv), "drive");
            i_host.write_reg(8'h01, 8'h3f ^ dv);
            repeat (4) @(negedge mclk_i);
            check(led_drive_o, 6'(~dv), "disable held");
            pwm_i = 1'b0;
            m[1] = 8'h3f ^ dv;
            repeat (8) @(negedge mclk_i);
            check_all();
        end
        end_of_test();
    end
endmodule // led_driver_config_regs_bench

`default_nettype wire
